// File: pkg/qps_pkg.sv
package qps_pkg;
  localparam int unsigned REF_CLK_HZ = 50_000_000;
  // Nonvolatile program cycle, longest
  localparam int unsigned PROG_TIME_MS = 5;
  localparam int unsigned PROG_CYC = (PROG_TIME_MS * REF_CLK_HZ) / 1000;
  // Arbitrary value for the fixed device-type nibble
  localparam logic [3:0] DEV_TYPE_CODE = 4'hA;
  localparam int unsigned NUM_POTS = 4;
  localparam int unsigned NUM_SLOTS = 4;
  localparam int unsigned WIPER_W = 6;
  localparam int unsigned NUM_TAPS = 64;
  localparam logic [5:0] WIPER_MAX = 6'h3F;
  // Contents of every setting slot when the part is new
  localparam logic [5:0] SLOT_INIT = 6'h00;
  // Instruction byte field positions
  localparam int unsigned OPC_POS = 4;
  localparam int unsigned POT_POS = 2;
  localparam int unsigned SLOT_POS = 0;
  // Filtered {strap[3:0], scl, sda} after reset: bus idle high
  localparam logic [5:0] PIN_F_RST = 6'h03;

  typedef enum logic [3:0] {
    OP_GS2W = 4'h1,
    OP_STEP = 4'h2,
    OP_GW2S = 4'h8,
    OP_RDW = 4'h9,
    OP_WRW = 4'hA,
    OP_RDS = 4'hB,
    OP_WRS = 4'hC,
    OP_S2W = 4'hD,
    OP_W2S = 4'hE
  } qps_op_type;

  typedef enum logic [2:0] {
    LS_IDLE = 3'b000,
    LS_ADDR = 3'b001,
    LS_INSTR = 3'b010,
    LS_DATA = 3'b011,
    LS_TX = 3'b100,
    LS_STEP = 3'b101,
    LS_WAIT = 3'b110
  } qps_lst_type;

  typedef struct packed {
    qps_op_type op;
    logic [1:0] pot;
    logic [1:0] slot;
    logic [5:0] data;
  } qps_req_type;
endpackage

// File: pkg/qps_nvm_if.sv
`timescale 1ns/1ns
interface qps_nvm_if;
  logic wr_en;
  logic [3:0] wr_mask;
  logic [1:0] wr_slot;
  logic [3:0][5:0] wr_data;
  logic [1:0] rd_slot;
  logic [3:0][5:0] rd_data;
  logic busy;
  modport ctl (
    output wr_en, wr_mask, wr_slot, wr_data, rd_slot,
    input rd_data, busy
  );
  modport mem (
    input wr_en, wr_mask, wr_slot, wr_data, rd_slot,
    output rd_data, busy
  );
endinterface // qps_nvm_if

// File: hw/qps_nvm.sv
`timescale 1ns/1ns
module qps_nvm
  import qps_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  qps_nvm_if.mem nv
);
  if (PROG_CYCLES < 2) begin : g_bad_prog
    $error("PROG_CYCLES must be at least 2");
  end

  // Slots survive reset; only power loss would clear them
  logic [5:0] mem_q [NUM_POTS][NUM_SLOTS] = '{default: SLOT_INIT};
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic busy_q;
  logic busy_d;
  logic start;

  assign start = nv.wr_en && !busy_q;

  always_comb begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    if (start) begin
      busy_d = 1'b1;
      cnt_d = PROG_CYCLES - 1;
    end else if (busy_q && cnt_q == 32'h0) begin
      busy_d = 1'b0;
    end else if (busy_q) begin
      cnt_d = cnt_q - 32'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_q <= 32'h0;
      busy_q <= 1'b0;
    end else if (ce) begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
    end
  end

  for (genvar g = 0; g < NUM_POTS; g++) begin : g_pot
    always_ff @(posedge ref_clk) begin
      if (ce && start && nv.wr_mask[g]) begin
        mem_q[g][nv.wr_slot] <= nv.wr_data[g];
      end
    end
    assign nv.rd_data[g] = mem_q[g][nv.rd_slot];
  end

  assign nv.busy = busy_q;

  AST_PROG_START: assert property ( // R2
    @(posedge ref_clk) disable iff (rst || !ce)
    start |=> busy_q && cnt_q == PROG_CYCLES - 1)
    else $error("program cycle did not start");
  AST_PROG_END: assert property ( // R2
    @(posedge ref_clk) disable iff (rst || !ce)
    busy_q && cnt_q == 32'h0 |=> !busy_q)
    else $error("program cycle overran");
  AST_BUSY_HOLD: assert property ( // R3
    @(posedge ref_clk) disable iff (rst || !ce)
    busy_q && cnt_q != 32'h0 |=> busy_q && cnt_q == $past(cnt_q) - 32'h1)
    else $error("program count broken");
endmodule // qps_nvm

// File: hw/qps_top.sv
`timescale 1ns/1ns
// How it works
// [R1] Master waits up to 1 ms after power before any access.
// [R2] Nonvolatile program starts at write STOP, finishes within 5 ms.
// [R3] While programming, data line released and own address ignored.
// [R4] Master starts transfers only on an idle bus.
// [R5] Data changes while clock high are START or STOP only.
// [R6] START is data falling with clock high; silent until one.
// [R7] STOP is data rising with clock high; ends every operation.
// [R8] Address byte: fixed type nibble plus four strap bits.
// [R9] Only a device matching its straps continues; others ignore.
// [R10] Receiver acknowledges by pulling data low on ninth clock.
// [R11] Acknowledge on matching address and every received write byte; an instruction byte with an unknown opcode gets no ack.
// [R12] Read: send 8 bits, release, continue on ack, else wait.
// [R13] Write is address, instruction, data, STOP; slot program then.
// [R14] Instruction: opcode top four, pot select two, slot select two.
// [R15] Slot select bits pick slot zero to three in binary.
// [R16] Polling address gets no ack until programming is done.
// [R17] Four 6-bit wiper registers, each decoded to one of 64 taps.
// [R18] Wiper changes only by write, transfer, step or power-up load.
// [R19] At power-up each wiper loads its own slot zero.
// [R20] Wipers are volatile; only slot zero is restored.
// [R21] Master makes all clocks and starts transfers; device is slave.
// [R22] After step command, clock with data high up, low down.
// [R23] Nine opcodes: reads, writes, four transfers, step.
// [R24] Stepping saturates at top and bottom taps.
// [R25] Six-bit values read back in low bits, top two zero.
module qps_top
  import qps_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic link_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [3:0] address_strap_pins,
  output logic [NUM_POTS-1:0][WIPER_W-1:0] wiper_position_register,
  output logic [NUM_POTS-1:0][NUM_TAPS-1:0] tap_select,
  output logic program_busy
);
  if (PROG_CYCLES < 2) begin : g_bad_prog
    $error("PROG_CYCLES must be at least 2");
  end

  qps_nvm_if nv ();

  // Link domain: reset, enable and pin synchronisers
  logic [1:0] lrst_q;
  logic [1:0] lce_q;
  logic lrst;
  logic lce;
  logic [5:0] pin_s1_q;
  logic [5:0] pin_s2_q;
  logic [5:0] pin_s3_q;
  logic [5:0] pin_f_q;
  logic [5:0] pin_f_d;
  logic scl_p_q;
  logic sda_p_q;
  logic [1:0] bs_q;
  logic scl_f;
  logic sda_f;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;

  always_ff @(posedge link_clk) begin
    lrst_q <= {lrst_q[0], rst};
    lce_q <= {lce_q[0], ce};
  end
  assign lrst = lrst_q[1];
  assign lce = lce_q[1];

  // A change counts once the second and third stages agree
  assign pin_f_d = (pin_s2_q & ~(pin_s2_q ^ pin_s3_q))
                 | (pin_f_q & (pin_s2_q ^ pin_s3_q));
  assign scl_f = pin_f_q[1];
  assign sda_f = pin_f_q[0];
  assign scl_rise = scl_f && !scl_p_q;
  assign scl_fall = !scl_f && scl_p_q;
  assign start = scl_f && scl_p_q && sda_p_q && !sda_f; // R5 R6
  assign stop = scl_f && scl_p_q && !sda_p_q && sda_f; // R5 R7

  always_ff @(posedge link_clk) begin
    if (lrst) begin
      pin_s1_q <= PIN_F_RST;
      pin_s2_q <= PIN_F_RST;
      pin_s3_q <= PIN_F_RST;
      pin_f_q <= PIN_F_RST;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      bs_q <= 2'h0;
    end else if (lce) begin
      pin_s1_q <= {address_strap_pins, scl_i, sda_i};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_f_q <= pin_f_d;
      scl_p_q <= scl_f;
      sda_p_q <= sda_f;
      bs_q <= {bs_q[0], nv.busy};
    end
  end

  // Link domain: serial engine
  qps_lst_type st_q;
  qps_lst_type st_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [7:0] sh_q;
  logic [7:0] sh_d;
  logic [7:0] tx_q;
  logic [7:0] tx_d;
  logic oe_q;
  logic oe_d;
  logic pend_q;
  logic pend_d;
  logic tgl_q;
  logic tgl_d;
  qps_req_type req_q;
  qps_req_type req_d;
  logic [5:0] rd_val_q;
  logic [7:0] rd_byte;
  qps_op_type in_op;
  logic byte_st;
  logic addr_ok;
  logic op_ok;

  assign in_op = qps_op_type'(sh_q[OPC_POS+:4]); // R14
  assign byte_st = st_q inside {LS_ADDR, LS_INSTR, LS_DATA, LS_TX};
  assign addr_ok = sh_q == {DEV_TYPE_CODE, pin_f_q[5:2]} && !bs_q[1];
  assign op_ok = in_op inside {OP_GS2W, OP_STEP, OP_GW2S, OP_RDW, OP_WRW,
                               OP_RDS, OP_WRS, OP_S2W, OP_W2S}; // R23
  // Word is quasi-static: changes only on a read, long before use
  assign rd_byte = {2'b00, rd_val_q}; // R25

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    tx_d = tx_q;
    oe_d = oe_q;
    pend_d = pend_q;
    tgl_d = tgl_q;
    req_d = req_q;
    if (start) begin
      st_d = LS_ADDR; // R6
      // First clock fall after START belongs to it, not to a bit
      cnt_d = 4'hF;
      oe_d = 1'b0;
      pend_d = 1'b0;
    end else if (stop) begin
      st_d = LS_IDLE; // R7
      oe_d = 1'b0;
      pend_d = 1'b0;
      if (pend_q) begin
        tgl_d = ~tgl_q; // R2 R13
      end
    end else begin
      if (scl_rise && byte_st && cnt_q != 4'h8) begin
        sh_d = {sh_q[6:0], sda_f};
      end
      if (scl_rise && st_q == LS_TX && cnt_q == 4'h8 && sda_f) begin
        st_d = LS_WAIT; // R12
      end
      if (scl_rise && st_q == LS_STEP) begin
        req_d.op = OP_STEP; // R22
        req_d.data = {5'h00, sda_f};
        tgl_d = ~tgl_q;
      end
      if (scl_fall && byte_st) begin
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == 4'h7) begin
          case (st_q)
            LS_ADDR: oe_d = addr_ok; // R3 R8 R9 R10 R11 R16
            LS_INSTR: begin
              oe_d = op_ok; // R11
              req_d.op = in_op;
              req_d.pot = sh_q[POT_POS+:2]; // R14
              req_d.slot = sh_q[SLOT_POS+:2]; // R15
              req_d.data = 6'h00;
              if (op_ok && in_op inside {OP_RDW, OP_RDS, OP_S2W, OP_GS2W}) begin
                tgl_d = ~tgl_q;
              end
              if (op_ok && in_op inside {OP_W2S, OP_GW2S}) begin
                pend_d = 1'b1; // R13
              end
            end
            LS_DATA: begin
              oe_d = 1'b1; // R11
              req_d.data = sh_q[WIPER_W-1:0];
              if (req_q.op == OP_WRW) begin
                tgl_d = ~tgl_q;
              end else begin
                pend_d = 1'b1; // R13
              end
            end
            default: oe_d = 1'b0; // R12
          endcase
        end else if (cnt_q == 4'h8) begin
          cnt_d = 4'h0;
          oe_d = 1'b0;
          case (st_q)
            LS_ADDR: st_d = oe_q ? LS_INSTR : LS_WAIT; // R9
            LS_INSTR: begin
              if (!oe_q) begin
                st_d = LS_WAIT;
              end else begin
                case (req_q.op)
                  OP_RDW, OP_RDS: st_d = LS_TX;
                  OP_WRW, OP_WRS: st_d = LS_DATA;
                  OP_STEP: st_d = LS_STEP;
                  default: st_d = LS_WAIT;
                endcase
              end
            end
            LS_TX: st_d = LS_TX;
            default: st_d = LS_WAIT;
          endcase
          if (st_d == LS_TX) begin
            oe_d = ~rd_byte[7]; // R12
            tx_d = {rd_byte[6:0], 1'b0};
          end
        end else if (st_q == LS_TX) begin
          oe_d = ~tx_q[7];
          tx_d = {tx_q[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge link_clk) begin
    if (lrst) begin
      st_q <= LS_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      oe_q <= 1'b0;
      pend_q <= 1'b0;
      tgl_q <= 1'b0;
      req_q <= '0;
      sda_o <= 1'b0;
    end else if (lce) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      oe_q <= oe_d;
      pend_q <= pend_d;
      tgl_q <= tgl_d;
      req_q <= req_d;
      sda_o <= 1'b0;
    end
  end
  assign sda_oe = oe_q;

  // Reference domain: wipers, taps, request execution
  logic [2:0] rtg_q;
  logic ev;
  logic init_q;
  logic init_d;
  logic [NUM_POTS-1:0][WIPER_W-1:0] wip_q;
  logic [NUM_POTS-1:0][WIPER_W-1:0] wip_d;
  logic [NUM_POTS-1:0][NUM_TAPS-1:0] tap_d;
  logic [5:0] rd_val_d;

  assign ev = rtg_q[1] ^ rtg_q[2];

  always_comb begin
    init_d = 1'b0;
    wip_d = wip_q;
    rd_val_d = rd_val_q;
    nv.wr_en = 1'b0;
    nv.wr_mask = 4'h0;
    nv.wr_slot = req_q.slot;
    nv.wr_data = (req_q.op == OP_WRS) ? {4{req_q.data}} : wip_q;
    nv.rd_slot = init_q ? 2'h0 : req_q.slot;
    if (init_q) begin
      wip_d = nv.rd_data; // R18 R19 R20
    end else if (ev) begin
      case (req_q.op)
        OP_RDW: rd_val_d = wip_q[req_q.pot];
        OP_RDS: rd_val_d = nv.rd_data[req_q.pot];
        OP_WRW: wip_d[req_q.pot] = req_q.data; // R18
        OP_S2W: wip_d[req_q.pot] = nv.rd_data[req_q.pot]; // R18
        OP_GS2W: wip_d = nv.rd_data; // R18
        OP_WRS, OP_W2S: begin
          nv.wr_en = 1'b1; // R2
          nv.wr_mask = 4'h1 << req_q.pot;
        end
        OP_GW2S: begin
          nv.wr_en = 1'b1; // R2
          nv.wr_mask = 4'hF;
        end
        OP_STEP: begin
          if (req_q.data[0] && wip_q[req_q.pot] != WIPER_MAX) begin
            wip_d[req_q.pot] = wip_q[req_q.pot] + 6'h01; // R22 R24
          end else if (!req_q.data[0] && wip_q[req_q.pot] != 6'h00) begin
            wip_d[req_q.pot] = wip_q[req_q.pot] - 6'h01; // R22 R24
          end
        end
        default: wip_d = wip_q;
      endcase
    end
  end

  for (genvar g = 0; g < NUM_POTS; g++) begin : g_tap
    assign tap_d[g] = 64'h1 << wip_d[g]; // R17
    AST_TAP_ONEHOT: assert property ( // R17
      @(posedge ref_clk) disable iff (rst)
      !init_q |-> $onehot(tap_select[g]))
      else $error("tap select not one-hot");
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rtg_q <= 3'h0;
      init_q <= 1'b1;
      wip_q <= '0;
      tap_select <= '0;
      rd_val_q <= 6'h00;
    end else if (ce) begin
      rtg_q <= {rtg_q[1:0], tgl_q};
      init_q <= init_d;
      wip_q <= wip_d;
      tap_select <= tap_d;
      rd_val_q <= rd_val_d;
    end
  end
  assign wiper_position_register = wip_q;
  assign program_busy = nv.busy;

  qps_nvm #(
    .PROG_CYCLES(PROG_CYCLES)
  ) u_nvm (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .nv(nv)
  );

  sequence s_nack_slot;
    scl_rise && st_q == LS_TX && cnt_q == 4'h8 && sda_f && !start && !stop;
  endsequence
  sequence s_addr_done;
    st_q == LS_ADDR && scl_fall && cnt_q == 4'h7 && !start && !stop;
  endsequence

  AST_START_ADDR: assert property ( // R6
    @(posedge link_clk) disable iff (lrst || !lce)
    start |=> st_q == LS_ADDR && cnt_q == 4'hF && !oe_q)
    else $error("start did not restart address phase");
  AST_NO_MATCH_SILENT: assert property ( // R9 R3 R16
    @(posedge link_clk) disable iff (lrst || !lce)
    s_addr_done and !addr_ok |=> !oe_q)
    else $error("acknowledged a foreign or busy address");
  AST_MATCH_ACK: assert property ( // R8 R11
    @(posedge link_clk) disable iff (lrst || !lce)
    s_addr_done and addr_ok |=> oe_q && cnt_q == 4'h8)
    else $error("matching address not acknowledged");
  AST_ACK_NINTH: assert property ( // R10
    @(posedge link_clk) disable iff (lrst || !lce)
    oe_q && st_q != LS_TX |-> cnt_q == 4'h8)
    else $error("ack outside ninth clock");
  AST_TX_NACK: assert property ( // R12
    @(posedge link_clk) disable iff (lrst || !lce)
    s_nack_slot |=> st_q == LS_WAIT ##1 !oe_q)
    else $error("transmit continued without ack");
  AST_STOP_COMMIT: assert property ( // R13 R2
    @(posedge link_clk) disable iff (lrst || !lce)
    stop && pend_q |=> tgl_q != $past(tgl_q) && !pend_q)
    else $error("stop did not start programming");
  AST_STEP_SAT: assert property ( // R24
    @(posedge ref_clk) disable iff (rst || !ce)
    !init_q && ev && req_q.op == OP_STEP && req_q.data[0]
    && wip_q[req_q.pot] == WIPER_MAX |=> wip_q == $past(wip_q))
    else $error("step passed the top tap");
  AST_POWERUP: assert property ( // R19
    @(posedge ref_clk) disable iff (rst || !ce)
    init_q |=> !init_q && wip_q == $past(nv.rd_data))
    else $error("power-up load missing");
  AST_WIPER_QUIET: assert property ( // R18
    @(posedge ref_clk) disable iff (rst || !ce)
    !init_q && !ev |=> $stable(wip_q))
    else $error("wiper changed without cause");
endmodule // qps_top

// File: dv/qps_bus_master.sv
`timescale 1ns/1ns
module qps_bus_master (
  input wire logic ref_clk,
  input wire logic sda_w,
  output logic scl,
  output logic sda_low
);
  localparam int Q = 8;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // One bus phase; sets clock and data together, then holds them for Q cycles
  task automatic drive(input logic c, input logic d);
    @(posedge ref_clk);
    scl <= c;
    sda_low <= ~d;
    repeat (Q - 1) @(posedge ref_clk);
  endtask
  task automatic lo();
    drive(1'b0, ~sda_low);
  endtask
  task automatic start();
    lo();
    drive(1'b0, 1'b1);
    drive(1'b1, 1'b1);
    drive(1'b1, 1'b0);
  endtask
  task automatic stop();
    lo();
    drive(1'b0, 1'b0);
    drive(1'b1, 1'b0);
    drive(1'b1, 1'b1);
  endtask
  task automatic bit_io(input logic d, output logic r);
    lo();
    drive(1'b0, d);
    drive(1'b1, d);
    r = sda_w;
  endtask
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic rd(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~mack, r);
  endtask
endmodule // qps_bus_master

// File: dv/quad_pot_serial_slave_tb.sv
`timescale 1ns/1ns
module quad_pot_serial_slave_tb
  import qps_pkg::*;
;
  localparam int unsigned PROG = 2000;
  localparam logic [3:0] STRAP = 4'h6;
  localparam logic [7:0] ADR = {DEV_TYPE_CODE, STRAP};
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic scl;
  logic sda_low;
  logic sda_o;
  logic sda_oe;
  logic program_busy;
  logic [3:0][5:0] wpr;
  logic [3:0][63:0] taps;
  // Pulled-up data line
  wire sda_w = ~(sda_low | sda_oe);
  int fail_count = 0;
  int n_checks = 0;

  always #10 ref_clk = ~ref_clk;
  always begin
    #7 link_clk = 1'b1;
    #8 link_clk = 1'b0;
  end

  qps_top #(.PROG_CYCLES(PROG)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .ce(1'b1), .link_clk(link_clk),
    .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
    .address_strap_pins(STRAP), .wiper_position_register(wpr),
    .tap_select(taps), .program_busy(program_busy));
  qps_bus_master m_u (.ref_clk(ref_clk), .sda_w(sda_w), .scl(scl),
    .sda_low(sda_low));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic do_reset();
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (20) @(posedge ref_clk);
  endtask
  // Address, instruction, optional data byte, then STOP
  task automatic xact(input logic [7:0] ad, input logic [7:0] ins,
      input logic [7:0] dat, input int nb, input logic [2:0] exp);
    logic [2:0] ak;
    ak = '0;
    m_u.start();
    m_u.wr(ad, ak[2]);
    m_u.wr(ins, ak[1]);
    if (nb == 3) m_u.wr(dat, ak[0]);
    m_u.stop();
    repeat (10) @(posedge ref_clk);
    chk(ak, exp);
  endtask
  // Two reads, acked then not acked
  task automatic rdx(input logic [7:0] ins, input logic [7:0] exp);
    logic x, y;
    logic [7:0] d1, d2;
    m_u.start();
    m_u.wr(ADR, x);
    m_u.wr(ins, y);
    m_u.rd(1'b1, d1);
    m_u.rd(1'b0, d2);
    m_u.stop();
    chk({x, y, d1, d2}, {2'b11, exp, exp});
  endtask
  task automatic prog_wait();
    logic a;
    int n;
    repeat (6) @(posedge ref_clk);
    chk(program_busy, 1'b1);
    m_u.start();
    m_u.wr(ADR, a);
    m_u.stop();
    chk(a, 1'b0);
    n = 0;
    while (program_busy === 1'b1 && n < PROG + 10) begin
      @(posedge ref_clk);
      n++;
    end
    chk(program_busy, 1'b0);
    m_u.start();
    m_u.wr(ADR, a);
    m_u.stop();
    chk(a, 1'b1);
  endtask
  // Step pulses; last one low so STOP needs no extra clock
  task automatic step(input logic [1:0] pot, input logic [7:0] pat,
      input int n);
    logic x, y;
    m_u.start();
    m_u.wr(ADR, x);
    m_u.wr({OP_STEP, pot, 2'b00}, y);
    for (int i = 0; i < n; i++) begin
      m_u.lo();
      m_u.drive(1'b0, pat[i]);
      m_u.drive(1'b1, pat[i]);
    end
    m_u.drive(1'b1, 1'b1);
    repeat (10) @(posedge ref_clk);
    chk({x, y}, 2'b11);
  endtask

  initial begin
    do_reset();
    chk(wpr, {4{SLOT_INIT}});
    chk(taps[0], 64'h1);
    chk(sda_o, 1'b0);
    xact(ADR, {OP_WRW, 4'h8}, 8'h2A, 3, 3'b111);
    chk(wpr[2], 6'h2A);
    chk(taps[2], 64'h1 << 42);
    rdx({OP_RDW, 4'h8}, 8'h2A);
    xact({DEV_TYPE_CODE, ~STRAP}, 8'hA8, 8'h05, 3, 3'b000);
    xact({~DEV_TYPE_CODE, STRAP}, 8'hA8, 8'h05, 3, 3'b000);
    chk(wpr[2], 6'h2A);
    xact(ADR, {OP_WRS, 4'h7}, 8'h15, 3, 3'b111);
    prog_wait();
    rdx({OP_RDS, 4'h7}, 8'h15);
    rdx({OP_RDS, 4'h4}, {2'b00, SLOT_INIT});
    xact(ADR, {OP_S2W, 4'h7}, 8'h00, 2, 3'b110);
    chk(wpr, {SLOT_INIT, 6'h2A, 6'h15, SLOT_INIT});
    step(2'd0, 8'b0000_1110, 5);
    xact(ADR, {OP_WRW, 4'hC}, 8'h3F, 3, 3'b111);
    step(2'd3, 8'b0000_0011, 3);
    chk(wpr, {6'h3E, 6'h2A, 6'h15, 6'h02});
    xact(ADR, 8'h30, 8'h00, 2, 3'b100);
    chk(wpr, {6'h3E, 6'h2A, 6'h15, 6'h02});
    xact(ADR, {OP_GW2S, 4'h0}, 8'h00, 2, 3'b110);
    prog_wait();
    xact(ADR, {OP_W2S, 4'h9}, 8'h00, 2, 3'b110);
    prog_wait();
    xact(ADR, {OP_GS2W, 4'h1}, 8'h00, 2, 3'b110);
    chk(wpr, {SLOT_INIT, 6'h2A, SLOT_INIT, SLOT_INIT});
    do_reset();
    chk(wpr, {6'h3E, 6'h2A, 6'h15, 6'h02});
    chk(taps[3], 64'h1 << 62);
    finish_test();
  end

  initial begin
    #1_500_000;
    fail_count++;
    finish_test();
  end
endmodule // quad_pot_serial_slave_tb
